// ---- common/rx_port_control_consts.vh ----
`ifndef RX_PORT_CONTROL_CONSTS_VH
`define RX_PORT_CONTROL_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_ESTORE_CTRL 10'h085
`define IDX_ERR_CFG 10'h086
`define IDX_HDLC_FIFO 10'h087
`define IDX_ILV_BUS 10'h088
`define IDX_CNT_LINE_VIOL 10'h0a0
`define IDX_CNT_FRAMING 10'h0a1
`define IDX_CNT_MF_OOS 10'h0a2
`define IDX_ESTORE_STAT 10'h0a3

// Reset values of the writable registers
`define RST_ESTORE_CTRL 8'h00
`define RST_ERR_CFG 8'h00
`define RST_HDLC_FIFO 8'h00
`define RST_ILV_BUS 8'h00

// Elastic store control fields
`define ES_ENABLE 0
`define ES_MIN_DELAY 1
`define ES_RESET 2
`define ES_ALIGN 3
`define ES_ZONE_SEL 4
`define ES_GAPPED_CLK 6
`define ES_RATE_FMT 7

// Error counter configuration fields
`define EC_LVZ 0
`define EC_MF_OOS 1
`define EC_SIG_FRAME 2
`define EC_ACCUM_MODE 3
`define EC_INTERVAL 4
`define EC_MANUAL_UPD 5
`define EC_MANUAL_SRC 6
`define EC_SHARED_SEC 7

// Interleave bus fields
`define ILV_SLOT_LSB 0
`define ILV_ENABLE 3
`define ILV_MODE 4
`define ILV_SIZE_LSB 5

// Timing, counted in received frames of 125 us
`define FRAME_US 125
`define SECOND_US 1000000
`define FRAMES_PER_SECOND (`SECOND_US / `FRAME_US)
`define T1_SHORT_FRAMES 333
`define E1_SHORT_FRAMES 500

// Elastic store geometry and slip zones in bytes
`define T1_FRAME_BYTES 24
`define E1_FRAME_BYTES 32
`define MIN_DELAY_BYTES 4
`define SLIP_ZONE_WIDE 9
`define SLIP_ZONE_NARROW 2

`endif

// ---- core/err_accum.v ----
`timescale 1ns/1ps
`include "rx_port_control_consts.vh"

module err_accum #(
    parameter CW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire update_i,
    input wire inc_line_i,
    input wire inc_framing_i,
    input wire inc_mf_i,
    output reg [CW-1:0] line_cnt_o,
    output reg [CW-1:0] framing_cnt_o,
    output reg [CW-1:0] mf_cnt_o
);
    reg [CW-1:0] run_line;
    reg [CW-1:0] run_framing;
    reg [CW-1:0] run_mf;

    // Saturating step; an event in the update cycle starts the new interval so it is not lost
    function [CW-1:0] step;
        input [CW-1:0] cnt;
        input inc;
        begin
            step = (inc && (cnt != {CW{1'b1}})) ? cnt + {{(CW-1){1'b0}}, 1'b1} : cnt;
        end
    endfunction

    // Running counters and their latched copies
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_line <= {CW{1'b0}};
            run_framing <= {CW{1'b0}};
            run_mf <= {CW{1'b0}};
            line_cnt_o <= {CW{1'b0}};
            framing_cnt_o <= {CW{1'b0}};
            mf_cnt_o <= {CW{1'b0}};
        end else if (update_i) begin
            line_cnt_o <= run_line;
            framing_cnt_o <= run_framing;
            mf_cnt_o <= run_mf;
            run_line <= {{(CW-1){1'b0}}, inc_line_i};
            run_framing <= {{(CW-1){1'b0}}, inc_framing_i};
            run_mf <= {{(CW-1){1'b0}}, inc_mf_i};
        end else begin
            run_line <= step(run_line, inc_line_i);
            run_framing <= step(run_framing, inc_framing_i);
            run_mf <= step(run_mf, inc_mf_i);
        end
    end
endmodule // err_accum

// ---- core/estore_ctrl.v ----
`timescale 1ns/1ps
`include "rx_port_control_consts.vh"

module estore_ctrl #(
    parameter AW = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire e1_mode_i,
    input wire enable_i,
    input wire min_delay_i,
    input wire zone_sel_i,
    input wire conv_i,
    input wire align_i,
    input wire reset_i,
    input wire wr_en_i,
    input wire [7:0] wr_data_i,
    input wire rd_en_i,
    output reg [7:0] rd_data_o,
    output reg slip_o,
    output wire [AW-1:0] sep_o
);
    reg [7:0] mem [0:(1<<AW)-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    localparam [AW-1:0] FR_E1 = `E1_FRAME_BYTES, FR_T1 = `T1_FRAME_BYTES, MIN_D = `MIN_DELAY_BYTES;
    localparam [AW-1:0] ZN_N = `SLIP_ZONE_NARROW, ZN_W = `SLIP_ZONE_WIDE;
    wire [AW-1:0] frame = e1_mode_i ? FR_E1 : FR_T1;
    wire [AW-1:0] depth = min_delay_i ? MIN_D : {frame[AW-2:0], 1'b0};
    wire [AW-1:0] half = min_delay_i ? MIN_D >> 1 : {1'b0, frame[AW-1:1]};
    wire [AW-1:0] zone = zone_sel_i ? ZN_N : ZN_W;
    wire [AW-1:0] wr_base = (wr_ptr < frame || min_delay_i) ? {AW{1'b0}} : frame;
    wire [AW-1:0] other_base = (wr_base == {AW{1'b0}} && !min_delay_i) ? frame : {AW{1'b0}};
    wire [AW-1:0] reset_sep = wr_ptr - wr_base;

    // Distance a-b around a store of the given depth; zero depth is 2^AW
    function [AW-1:0] wrap_sub;
        input [AW-1:0] a;
        input [AW-1:0] b;
        input [AW-1:0] d;
        begin
            wrap_sub = (a >= b) ? a - b : a + d - b;
        end
    endfunction

    function [AW-1:0] wrap_inc;
        input [AW-1:0] a;
        input [AW-1:0] d;
        begin
            wrap_inc = ({1'b0, a} + 1'b1 >= {d == {AW{1'b0}}, d}) ? {AW{1'b0}} : a + 1'b1;
        end
    endfunction

    assign sep_o = wrap_sub(wr_ptr, rd_ptr, depth);

    // Write side
    always @(posedge clk_i) begin
        if (wr_en_i)
            mem[wr_ptr] <= wr_data_i;
    end

    // Pointer control: reset beats align beats slip beats normal reads
    always @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            slip_o <= 1'b0;
        end else begin
            slip_o <= 1'b0;
            if (wr_en_i)
                wr_ptr <= wrap_inc(wr_ptr, depth);
            if (reset_i) begin
                if (conv_i && reset_sep <= zone) begin // R6
                    rd_ptr <= other_base;
                    slip_o <= 1'b1;
                end else begin
                    rd_ptr <= wr_base; // R6
                end
            end else if (align_i) begin
                if (sep_o < half) // R4
                    rd_ptr <= wrap_sub(wr_ptr, half, depth);
            end else if (conv_i && rd_en_i && sep_o <= zone) begin
                rd_ptr <= wrap_sub(rd_ptr, min_delay_i ? half : frame, depth); // R3
                slip_o <= 1'b1;
            end else if (rd_en_i) begin
                rd_ptr <= wrap_inc(rd_ptr, depth);
            end
        end
    end

    // Read data, or the line byte itself when the store is bypassed
    always @(posedge clk_i) begin
        if (rst_i)
            rd_data_o <= 8'h00;
        else if (!enable_i && wr_en_i)
            rd_data_o <= wr_data_i; // R9
        else if (enable_i && rd_en_i)
            rd_data_o <= mem[rd_ptr]; // R9
    end
endmodule // estore_ctrl

// ---- core/rx_port_control_registers.v ----
// Function
// R1: Clear means 64k in eight bits, set 56k
// R2: Gapped clock enable gates channel clock output
// R3: Slip near pointers during rate conversion
// R4: Align rising edge separates pointers half frame
// R5: Software aligns only with stable system clock
// R6: Reset rising edge; slip if inside zone
// R7: Software pulses reset, never leaves it set
// R8: Minimum delay selects 32-bit store depth
// R9: Store enable bypasses or inserts the store
// R10: Shared second uses port one's timer
// R11: Manual source picks update bit or latch
// R12: Manual update edge latches then clears counters
// R13: Software waits 250us before reading counts
// R14: Timed update each second or short interval
// R15: Accumulation mode selects timed or manual updates
// R16: Signaling framing errors counted when enabled
// R17: Multiframe counter counts errors or out-of-sync
// R18: Line violation counter includes excess zeros optionally
// R19: Watermark codes give 4/16/32/48 bytes
// R20: Bus size codes give 2/4/8 devices
// R21: Interleave enable; channel or frame mode
// R22: Slot position code k means slot k+1
// R23: Commands are rising edges, taken in-domain
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "rx_port_control_consts.vh"

module rx_port_control_registers #(
    parameter CW = 16,
    parameter AW = 6
) (
    input wire clk_i,
    input wire rst_i,
    // Classic Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Line and mode context
    input wire e1_mode_i,
    input wire rate_conv_i,
    input wire frame_tick_i,
    input wire port1_second_i,
    input wire ext_counter_latch_i,
    output reg second_tick_o,
    // Error events from the framer
    input wire line_viol_i,
    input wire excess_zero_i,
    input wire ft_err_i,
    input wire fs_err_i,
    input wire mf_oos_i,
    // Receive data path through the elastic store
    input wire line_byte_valid_i,
    input wire [7:0] line_byte_i,
    input wire sys_byte_read_i,
    output wire [7:0] rx_byte_o,
    output reg chan_rate_format_o,
    output wire slip_o,
    // Channel clock
    input wire chan_clk_i,
    input wire chan_active_i,
    input wire chan_last_bit_i,
    output reg rx_channel_clk_out_o,
    // HDLC and interleave decode
    output reg [5:0] fifo_high_mark_o,
    output reg ilv_active_o,
    output reg ilv_frame_mode_o,
    output reg [3:0] ilv_devices_o,
    output reg [3:0] ilv_slot_position_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_TICK = 3'b010;
    localparam ST_HOLD = 3'b100;

    reg [7:0] estore_ctrl_reg;
    reg [7:0] err_cfg_reg;
    reg [7:0] hdlc_fifo_reg;
    reg [7:0] ilv_bus_reg;
    reg align_prev;
    reg reset_prev;
    reg manual_prev;
    reg latch_prev;
    reg align_pulse;
    reg reset_pulse;
    reg manual_pulse;
    reg [13:0] sec_frames;
    reg [13:0] short_frames;
    reg short_tick;
    reg [2:0] upd_state;
    reg [2:0] next_upd_state;
    reg [15:0] slip_count;
    wire [CW-1:0] line_cnt;
    wire [CW-1:0] framing_cnt;
    wire [CW-1:0] mf_cnt;
    wire [AW-1:0] sep;
    wire bus_req = cyc_i & stb_i;
    wire [9:0] idx = adr_i[11:2];
    wire wr_lane0 = bus_req & we_i & sel_i[0] & ~ack_o;
    wire t1_mode = ~e1_mode_i;
    localparam [13:0] SH_E1 = `E1_SHORT_FRAMES, SH_T1 = `T1_SHORT_FRAMES;
    wire [13:0] short_limit = e1_mode_i ? SH_E1 : SH_T1;
    wire manual_mode = err_cfg_reg[`EC_ACCUM_MODE];
    wire latch_rise = ext_counter_latch_i & ~latch_prev;
    wire timed_event;
    wire manual_event;
    wire update_req;
    wire inc_line;
    wire inc_framing;
    wire inc_mf;

    // Watermark decode, used only for the fifo_high_mark_o output; readback returns the raw code
    function [5:0] mark_bytes;
        input [1:0] code;
        begin
            case (code)
                2'b00: mark_bytes = 6'd4;
                2'b01: mark_bytes = 6'd16;
                2'b10: mark_bytes = 6'd32;
                default: mark_bytes = 6'd48;
            endcase
        end
    endfunction

    // Device count on the interleaved bus; zero flags the reserved code
    function [3:0] bus_devices;
        input [1:0] code;
        begin
            case (code)
                2'b00: bus_devices = 4'd2;
                2'b01: bus_devices = 4'd4;
                2'b10: bus_devices = 4'd8;
                default: bus_devices = 4'd0;
            endcase
        end
    endfunction

    // Register writes; only byte lane 0 carries data, the rest is ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            estore_ctrl_reg <= `RST_ESTORE_CTRL;
            err_cfg_reg <= `RST_ERR_CFG;
            hdlc_fifo_reg <= `RST_HDLC_FIFO;
            ilv_bus_reg <= `RST_ILV_BUS;
        end else if (wr_lane0) begin
            case (idx)
                `IDX_ESTORE_CTRL: estore_ctrl_reg <= {dat_i[7:6], 1'b0, dat_i[4:0]};
                `IDX_ERR_CFG: err_cfg_reg <= dat_i[7:0];
                `IDX_HDLC_FIFO: hdlc_fifo_reg <= {6'h00, dat_i[1:0]};
                `IDX_ILV_BUS: ilv_bus_reg <= {1'b0, dat_i[6:0]};
                default: ;
            endcase
        end
    end

    // Wishbone answer one cycle after the strobe; unmapped reads give zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req & ~ack_o;
            dat_o <= 32'h00000000;
            if (bus_req && !ack_o && !we_i) begin
                case (idx)
                    `IDX_ESTORE_CTRL: dat_o <= {24'h000000, estore_ctrl_reg};
                    `IDX_ERR_CFG: dat_o <= {24'h000000, err_cfg_reg};
                    `IDX_HDLC_FIFO: dat_o <= {24'h000000, hdlc_fifo_reg};
                    `IDX_ILV_BUS: dat_o <= {24'h000000, ilv_bus_reg};
                    `IDX_CNT_LINE_VIOL: dat_o <= {{(32-CW){1'b0}}, line_cnt};
                    `IDX_CNT_FRAMING: dat_o <= {{(32-CW){1'b0}}, framing_cnt};
                    `IDX_CNT_MF_OOS: dat_o <= {{(32-CW){1'b0}}, mf_cnt};
                    `IDX_ESTORE_STAT: dat_o <= {slip_count, {(16-AW){1'b0}}, sep};
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Command bits act on their rising edge only; the store runs on this
    // clock, so the edge pulse is already in the domain it acts on
    always @(posedge clk_i) begin
        if (rst_i) begin
            align_prev <= 1'b0;
            reset_prev <= 1'b0;
            manual_prev <= 1'b0;
            latch_prev <= 1'b0;
            align_pulse <= 1'b0;
            reset_pulse <= 1'b0;
            manual_pulse <= 1'b0;
        end else begin
            align_prev <= estore_ctrl_reg[`ES_ALIGN];
            reset_prev <= estore_ctrl_reg[`ES_RESET];
            manual_prev <= err_cfg_reg[`EC_MANUAL_UPD];
            latch_prev <= ext_counter_latch_i;
            align_pulse <= estore_ctrl_reg[`ES_ALIGN] & ~align_prev; // R23 R4
            reset_pulse <= estore_ctrl_reg[`ES_RESET] & ~reset_prev; // R23 R6
            manual_pulse <= err_cfg_reg[`EC_MANUAL_UPD] & ~manual_prev; // R23 R12
        end
    end

    // Frame-based timers: one second and the short interval
    always @(posedge clk_i) begin
        if (rst_i) begin
            sec_frames <= 14'd0;
            short_frames <= 14'd0;
            second_tick_o <= 1'b0;
            short_tick <= 1'b0;
        end else begin
            second_tick_o <= 1'b0;
            short_tick <= 1'b0;
            if (frame_tick_i) begin
                if (sec_frames == `FRAMES_PER_SECOND - 1) begin
                    sec_frames <= 14'd0;
                    second_tick_o <= 1'b1; // R14
                end else begin
                    sec_frames <= sec_frames + 14'd1;
                end
                if (short_frames >= short_limit - 14'd1) begin
                    short_frames <= 14'd0;
                    short_tick <= 1'b1; // R14
                end else begin
                    short_frames <= short_frames + 14'd1;
                end
            end
        end
    end

    // Timed source: own second, port one's second, or the short interval
    assign timed_event = err_cfg_reg[`EC_INTERVAL] ? short_tick : // R14
        (err_cfg_reg[`EC_SHARED_SEC] ? port1_second_i : second_tick_o); // R10
    // Manual source: update bit edge or external latch edge
    assign manual_event = err_cfg_reg[`EC_MANUAL_SRC] ? latch_rise : manual_pulse; // R11
    assign update_req = manual_mode ? manual_event : timed_event; // R15

    // Update sequencer: a request enters ST_TICK on the next edge; counts latch on the edge after that
    always @* begin
        next_upd_state = upd_state;
        case (upd_state)
            ST_IDLE: if (update_req) next_upd_state = ST_TICK;
            ST_TICK: next_upd_state = update_req ? ST_TICK : ST_HOLD;
            ST_HOLD: next_upd_state = update_req ? ST_TICK : ST_IDLE;
            default: next_upd_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i)
            upd_state <= ST_IDLE;
        else
            upd_state <= next_upd_state;
    end

    // Event selection per counter function
    assign inc_line = line_viol_i | (err_cfg_reg[`EC_LVZ] & excess_zero_i); // R18
    assign inc_framing = ft_err_i | (t1_mode & err_cfg_reg[`EC_SIG_FRAME] & fs_err_i); // R16
    assign inc_mf = (t1_mode & err_cfg_reg[`EC_MF_OOS]) ? mf_oos_i : inc_framing; // R17

    err_accum #(
        .CW(CW)
    ) u_err_accum (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .update_i(upd_state == ST_TICK), // R12
        .inc_line_i(inc_line),
        .inc_framing_i(inc_framing),
        .inc_mf_i(inc_mf),
        .line_cnt_o(line_cnt),
        .framing_cnt_o(framing_cnt),
        .mf_cnt_o(mf_cnt)
    );

    estore_ctrl #(
        .AW(AW)
    ) u_estore_ctrl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .e1_mode_i(e1_mode_i),
        .enable_i(estore_ctrl_reg[`ES_ENABLE]), // R9
        .min_delay_i(estore_ctrl_reg[`ES_MIN_DELAY]), // R8
        .zone_sel_i(estore_ctrl_reg[`ES_ZONE_SEL]), // R3
        .conv_i(rate_conv_i),
        .align_i(align_pulse),
        .reset_i(reset_pulse),
        .wr_en_i(line_byte_valid_i),
        .wr_data_i(line_byte_i),
        .rd_en_i(estore_ctrl_reg[`ES_ENABLE] ? sys_byte_read_i : line_byte_valid_i),
        .rd_data_o(rx_byte_o),
        .slip_o(slip_o),
        .sep_o(sep)
    );

    // Slip count for software; wraps rather than saturating
    always @(posedge clk_i) begin
        if (rst_i)
            slip_count <= 16'h0000;
        else if (slip_o)
            slip_count <= slip_count + 16'h0001;
    end

    // Channel clock: gapped form skips idle channels and the unused bit at 56k.
    // Registered, so the clock output lags its input by one cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_channel_clk_out_o <= 1'b0;
            chan_rate_format_o <= 1'b0;
        end else begin
            chan_rate_format_o <= estore_ctrl_reg[`ES_RATE_FMT]; // R1
            if (estore_ctrl_reg[`ES_GAPPED_CLK])
                rx_channel_clk_out_o <= chan_clk_i & chan_active_i &
                    ~(estore_ctrl_reg[`ES_RATE_FMT] & chan_last_bit_i); // R2 R1
            else
                rx_channel_clk_out_o <= chan_clk_i; // R2
        end
    end

    // HDLC watermark and interleave bus decode
    always @(posedge clk_i) begin
        if (rst_i) begin
            fifo_high_mark_o <= 6'd4;
            ilv_active_o <= 1'b0;
            ilv_frame_mode_o <= 1'b0;
            ilv_devices_o <= 4'd2;
            ilv_slot_position_o <= 4'd1;
        end else begin
            fifo_high_mark_o <= mark_bytes(hdlc_fifo_reg[1:0]); // R19
            ilv_active_o <= ilv_bus_reg[`ILV_ENABLE]; // R21
            ilv_frame_mode_o <= ilv_bus_reg[`ILV_ENABLE] & ilv_bus_reg[`ILV_MODE]; // R21
            ilv_devices_o <= bus_devices(ilv_bus_reg[`ILV_SIZE_LSB+1:`ILV_SIZE_LSB]); // R20
            ilv_slot_position_o <= {1'b0, ilv_bus_reg[`ILV_SLOT_LSB+2:`ILV_SLOT_LSB]} + 4'd1; // R22
        end
    end
endmodule // rx_port_control_registers

// ---- verification/rx_port_control_asserts.sv ----
`timescale 1ns/1ps
`include "rx_port_control_consts.vh"

module rx_port_control_asserts #(
    parameter CW = 16,
    parameter AW = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire chan_rate_format_o,
    input wire [5:0] fifo_high_mark_o,
    input wire ilv_active_o,
    input wire ilv_frame_mode_o,
    input wire [3:0] ilv_devices_o,
    input wire [3:0] ilv_slot_position_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Store control writes
    wire wr_est = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & (adr_i[11:2] == `IDX_ESTORE_CTRL);
    reg fmt_q = 1'b0;
    always @(posedge clk_i) begin
        if (wr_est) fmt_q <= dat_i[7];
    end

    // Bus steps: a fresh request, then a one-cycle answer
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence

    a_ack_one_cycle: assert property (s_req |=> s_ans) else $error("ack not a single pulse after request");
    a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero when idle");
    a_rate_fmt_copy: assert property (wr_est |=> ##[0:2] chan_rate_format_o == fmt_q)
        else $error("rate format output does not follow register");
    a_hwm_legal: assert property (fifo_high_mark_o inside {6'h04, 6'h10, 6'h20, 6'h30})
        else $error("watermark not a legal value");
    a_devices_legal: assert property (ilv_devices_o inside {4'h0, 4'h2, 4'h4, 4'h8})
        else $error("bus size not a legal value");
    a_slot_range: assert property (ilv_slot_position_o inside {[4'h1:4'h8]})
        else $error("slot outside one to eight");
    a_frame_needs_active: assert property (!ilv_active_o |-> !ilv_frame_mode_o)
        else $error("frame interleave while bus disabled");
    a_reset_defaults: assert property ($fell(rst_i) |-> !ack_o && fifo_high_mark_o == 6'h04
        && ilv_devices_o == 4'h2 && ilv_slot_position_o == 4'h1) else $error("outputs not at reset values");
endmodule // rx_port_control_asserts

bind rx_port_control_registers rx_port_control_asserts #(.CW(CW), .AW(AW)) i_rx_port_control_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chan_rate_format_o(chan_rate_format_o),
    .fifo_high_mark_o(fifo_high_mark_o), .ilv_active_o(ilv_active_o), .ilv_frame_mode_o(ilv_frame_mode_o),
    .ilv_devices_o(ilv_devices_o), .ilv_slot_position_o(ilv_slot_position_o));

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`include "rx_port_control_consts.vh"

module testbench;
    reg clk_i;
    reg rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, e1 = 1'b0, latch = 1'b0, lbv = 1'b0;
    reg ck = 1'b0, lastb = 1'b0, p1 = 1'b0, pc;
    reg [11:0] adr = 12'h000;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h0, r;
    reg [7:0] lbyte = 8'h00, d;
    reg [4:0] evt = 5'h00; // Frame tick, fs, ft, excess zero, line violation
    reg [32:0] note;
    reg [32:0] q[$];
    reg [7:0] msk[4] = '{8'hdf, 8'hff, 8'h03, 8'h7f};
    reg [5:0] hwm[4] = '{6'h04, 6'h10, 6'h20, 6'h30};
    reg [3:0] dev[4] = '{4'h2, 4'h4, 4'h8, 4'h0};
    integer bad_count = 0, n_checks = 0, seed = 32'h3784, i, n;
    wire [31:0] dat_o;
    wire [7:0] rx_byte;
    wire [5:0] mark;
    wire [3:0] devs, slot;
    wire ack_o, fmt, chclk, act, frm;

    rx_port_control_registers #(.CW(16), .AW(6)) i_rx_port_control_registers (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .e1_mode_i(e1), .rate_conv_i(1'b0), .frame_tick_i(evt[4]),
        .port1_second_i(p1), .ext_counter_latch_i(latch), .second_tick_o(), .line_viol_i(evt[0]),
        .excess_zero_i(evt[1]), .ft_err_i(evt[2]), .fs_err_i(evt[3]), .mf_oos_i(evt[3]),
        .line_byte_valid_i(lbv), .line_byte_i(lbyte), .sys_byte_read_i(1'b0), .rx_byte_o(rx_byte),
        .chan_rate_format_o(fmt), .slip_o(), .chan_clk_i(ck), .chan_active_i(1'b1), .chan_last_bit_i(lastb),
        .rx_channel_clk_out_o(chclk), .fifo_high_mark_o(mark), .ilv_active_o(act), .ilv_frame_mode_o(frm),
        .ilv_devices_o(devs), .ilv_slot_position_o(slot));

    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task chk(input string nm, input [31:0] e, input [31:0] s);
        n_checks = n_checks + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One classic cycle
    task wb(input w, input [9:0] idx, input [7:0] wd, input [32:0] nt);
        @(posedge clk_i);
        r = $random(seed);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= 4'h1; dat <= {r[31:8], wd};
        q.push_back(nt);
        n = 0;
        do begin @(posedge clk_i); n = n + 1; end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("ack wait", 1, 0);
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task wr(input [9:0] idx, input [7:0] wd); wb(1'b1, idx, wd, 33'h0); endtask
    task rd(input [9:0] idx, input [7:0] e); wb(1'b0, idx, 8'h00, {9'h100, 16'h0, e}); endtask
    task ev(input [4:0] m, input integer k);
        repeat (k) begin @(posedge clk_i) evt <= m; @(posedge clk_i) evt <= 5'h00; end
    endtask
    task wt; repeat (10) @(posedge clk_i); endtask

    // Result watcher: each answer consumes the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1) begin
            if (q.size() == 0) chk("unexpected ack", 1, 0);
            else begin
                note = q.pop_front();
                if (note[32]) chk("read data", note[31:0], dat_o);
            end
        end
    end

    // Random channel clock and last-bit marker
    always @(posedge clk_i) begin
        ck <= $random(seed);
        lastb <= $random(seed);
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 4; i = i + 1) rd(10'(`IDX_ESTORE_CTRL + i), 8'h00);
        chk("mark", 6'h04, mark);
        chk("devices", 4'h2, devs);
        for (i = 0; i < 4; i = i + 1) begin
            d = $random(seed);
            wr(10'(`IDX_ESTORE_CTRL + i), d);
            rd(10'(`IDX_ESTORE_CTRL + i), d & msk[i]);
        end
        // Unmapped place: writes vanish, reads give zero
        wr(10'h089, 8'hff); rd(10'h089, 8'h00); rd(10'h3ff, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`IDX_HDLC_FIFO, 8'(i)); repeat (2) @(posedge clk_i);
            chk("mark", hwm[i], mark);
        end
        for (i = 0; i < 16; i = i + 1) begin
            r = $random(seed); d = {1'b0, 2'(i), r[4:0]};
            wr(`IDX_ILV_BUS, d); repeat (2) @(posedge clk_i);
            chk("devices", dev[d[6:5]], devs);
            chk("active", d[3], act);
            chk("frame mode", d[4] & d[3], frm);
            chk("slot", d[2:0] + 4'h1, slot);
        end
        // Store and gapped clock off: clock one cycle late, bytes pass through
        wr(`IDX_ESTORE_CTRL, 8'h00); repeat (3) @(posedge clk_i); pc = ck;
        for (i = 0; i < 20; i = i + 1) begin
            @(posedge clk_i); chk("channel clock", pc, chclk); pc = ck;
        end
        for (i = 0; i < 8; i = i + 1) begin
            d = $random(seed);
            @(posedge clk_i) begin lbv <= 1'b1; lbyte <= d; end
            @(posedge clk_i) lbv <= 1'b0;
            @(posedge clk_i) chk("bypass byte", d, rx_byte);
        end
        wr(`IDX_ESTORE_CTRL, 8'h09); rd(`IDX_ESTORE_STAT, 8'h0c);
        wr(`IDX_ESTORE_CTRL, 8'h05); wr(`IDX_ESTORE_CTRL, 8'h01); rd(`IDX_ESTORE_STAT, 8'h00);
        // Manual update, excess zeros and signaling errors excluded, then included
        wr(`IDX_ERR_CFG, 8'h08); ev(5'h01, 3); ev(5'h02, 2); ev(5'h04, 2); ev(5'h08, 3);
        wr(`IDX_ERR_CFG, 8'h28); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h03);
        rd(`IDX_CNT_FRAMING, 8'h02);
        wr(`IDX_ERR_CFG, 8'h0f); ev(5'h01, 1); ev(5'h02, 2); ev(5'h04, 1); ev(5'h08, 2);
        wr(`IDX_ERR_CFG, 8'h2f); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h03);
        rd(`IDX_CNT_FRAMING, 8'h03); rd(`IDX_CNT_MF_OOS, 8'h02);
        // External latch input, then port one's second, as the update source
        wr(`IDX_ERR_CFG, 8'h48); ev(5'h01, 4);
        @(posedge clk_i) latch <= 1'b1; wt; latch <= 1'b0;
        rd(`IDX_CNT_LINE_VIOL, 8'h04);
        wr(`IDX_ERR_CFG, 8'h80); ev(5'h01, 5); p1 <= 1'b1; @(posedge clk_i) p1 <= 1'b0; wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h05);
        // Timed short interval: nothing one frame early, update on the exact frame
        wr(`IDX_ERR_CFG, 8'h10); ev(5'h01, 2); ev(5'h10, `T1_SHORT_FRAMES - 1); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h05);
        ev(5'h10, 1); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h02);
        @(posedge clk_i) e1 <= 1'b1;
        ev(5'h01, 1); ev(5'h10, `E1_SHORT_FRAMES - 1); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h02);
        ev(5'h10, 1); wt;
        rd(`IDX_CNT_LINE_VIOL, 8'h01);
        results;
    end

    // Hang guard, far past the few thousand cycles needed
    initial begin
        repeat (20000) @(posedge clk_i);
        chk("watchdog", 0, 1);
        results;
    end
endmodule // testbench
